// ---- rtl/mie_pkg.sv ----
// constants and state types for the measurement interrupt enable block
package mie_pkg;

   // core sfr addresses of the three enable registers
   localparam logic [7:0] MIE_EN_LOW_OFS   = 8'hd9;
   localparam logic [7:0] MIE_EN_MID_OFS   = 8'hda;
   localparam logic [7:0] MIE_EN_HIGH_OFS  = 8'hdb;
   // status register that carries the summary bit (owned by the datapath)
   localparam logic [7:0] MIE_STAT_LOW_OFS = 8'hdc;

   // number of enable/status register pairs
   localparam int MIE_NREG = 3;
   localparam int MIE_IDX_LOW  = 0;
   localparam int MIE_IDX_MID  = 1;
   localparam int MIE_IDX_HIGH = 2;

   // address table, index 0 is the low register
   localparam logic [MIE_NREG-1:0][7:0] MIE_EN_OFS = {MIE_EN_HIGH_OFS, MIE_EN_MID_OFS, MIE_EN_LOW_OFS};

   // writable bits per register; reserved bits read zero and gate nothing
   localparam logic [7:0] MIE_EN_LOW_MASK  = 8'h3f;
   localparam logic [7:0] MIE_EN_MID_MASK  = 8'hff;
   localparam logic [7:0] MIE_EN_HIGH_MASK = 8'h3f;
   localparam logic [MIE_NREG-1:0][7:0] MIE_EN_MASK = {MIE_EN_HIGH_MASK, MIE_EN_MID_MASK, MIE_EN_LOW_MASK};

   // value of every enable register after reset
   localparam logic [7:0] MIE_EN_RST = 8'h00;
   // value of the read data register after reset
   localparam logic [7:0] MIE_RDATA_RST = 8'h00;

   // bit positions in the low enable/status pair
   localparam int MIE_B_FAULT_MODE_CHANGE    = 5;
   localparam int MIE_B_REACTIVE_SIGN_CHANGE = 4;
   localparam int MIE_B_ACTIVE_SIGN_CHANGE   = 3;
   localparam int MIE_B_APPARENT_NO_LOAD     = 2;
   localparam int MIE_B_REACTIVE_NO_LOAD     = 1;
   localparam int MIE_B_ACTIVE_NO_LOAD       = 0;
   localparam int MIE_B_SUMMARY              = 7;

   // bit positions in the mid enable/status pair
   localparam int MIE_B_PULSE_OUTPUT_TWO        = 7;
   localparam int MIE_B_PULSE_OUTPUT_ONE        = 6;
   localparam int MIE_B_APPARENT_ENERGY_OVF     = 5;
   localparam int MIE_B_REACTIVE_ENERGY_OVF     = 4;
   localparam int MIE_B_ACTIVE_ENERGY_OVF       = 3;
   localparam int MIE_B_APPARENT_ENERGY_HALF    = 2;
   localparam int MIE_B_REACTIVE_ENERGY_HALF    = 1;
   localparam int MIE_B_ACTIVE_ENERGY_HALF      = 0;

   // bit positions in the high enable/status pair
   localparam int MIE_B_WAVEFORM_SAMPLE_READY = 5;
   localparam int MIE_B_CURRENT_PEAK_EXCEEDED = 4;
   localparam int MIE_B_VOLTAGE_PEAK_EXCEEDED = 3;
   localparam int MIE_B_LINE_CYCLE_ACCUM_DONE = 2;
   localparam int MIE_B_ZERO_CROSS_TIMEOUT    = 1;
   localparam int MIE_B_ZERO_CROSS_DETECT     = 0;

   // state of one enable register
   typedef struct packed {
      logic [7:0] en;
   } mie_reg_state_t;

   // state of the combining logic
   typedef struct packed {
      logic                        irq;
      logic                        summary;
      logic [7:0]                  rdata;
      logic [MIE_NREG-1:0][7:0]    pend;
   } mie_core_state_t;

endpackage

// ---- rtl/mie_en_reg.sv ----
// one eight-bit interrupt enable register on the core sfr bus
`timescale 1ns/100ps
module mie_en_reg
   import mie_pkg::*;
#(
   parameter logic [7:0] ADDR = 8'h00,
   parameter logic [7:0] MASK = 8'hff
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic [7:0] sfr_wdata,
   output logic            hit,
   output logic [7:0]      en
);

   mie_reg_state_t st_r;
   mie_reg_state_t st_nxt;

   // address decode for this register
   assign hit = (sfr_addr == ADDR);

   // write path, reserved bits forced low
   always_comb begin
      st_nxt = st_r;
      if (sfr_wr && hit) begin
         st_nxt.en = sfr_wdata & MASK;
      end
   end

   // register, cleared so no source is enabled after reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r.en <= MIE_EN_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign en = st_r.en;

endmodule // mie_en_reg

// ---- rtl/mie_irq_core.sv ----
// measurement interrupt enable and combining logic with its sfr registers
`timescale 1ns/100ps

module mie_irq_core
   import mie_pkg::*;
(
   input  wire logic       MCLK,
   input  wire logic       RST_N,
   // core sfr bus
   input  wire logic [7:0] SFR_ADDR,
   input  wire logic       SFR_WR,
   input  wire logic       SFR_RD,
   input  wire logic [7:0] SFR_WDATA,
   output logic [7:0]      SFR_RDATA,
   output logic            SFR_HIT,
   // status flags from the metering datapath, low group
   input  wire logic       FAULT_MODE_CHANGE,
   input  wire logic       REACTIVE_SIGN_CHANGE,
   input  wire logic       ACTIVE_SIGN_CHANGE,
   input  wire logic       APPARENT_NO_LOAD,
   input  wire logic       REACTIVE_NO_LOAD,
   input  wire logic       ACTIVE_NO_LOAD,
   // status flags, mid group
   input  wire logic       PULSE_OUTPUT_TWO,
   input  wire logic       PULSE_OUTPUT_ONE,
   input  wire logic       APPARENT_ENERGY_OVERFLOW,
   input  wire logic       REACTIVE_ENERGY_OVERFLOW,
   input  wire logic       ACTIVE_ENERGY_OVERFLOW,
   input  wire logic       APPARENT_ENERGY_HALF_FULL,
   input  wire logic       REACTIVE_ENERGY_HALF_FULL,
   input  wire logic       ACTIVE_ENERGY_HALF_FULL,
   // status flags, high group
   input  wire logic       WAVEFORM_SAMPLE_READY,
   input  wire logic       CURRENT_PEAK_EXCEEDED,
   input  wire logic       VOLTAGE_PEAK_EXCEEDED,
   input  wire logic       LINE_CYCLE_ACCUM_DONE,
   input  wire logic       ZERO_CROSS_TIMEOUT,
   input  wire logic       ZERO_CROSS_DETECT,
   // results
   output logic            MEAS_IRQ,
   output logic            MEAS_IRQ_SUMMARY,
   output logic [7:0]      MEAS_IRQ_SRC_LOW,
   output logic [7:0]      MEAS_IRQ_SRC_MID,
   output logic [7:0]      MEAS_IRQ_SRC_HIGH
);

   // state of the combining logic
   mie_core_state_t             st_r;
   mie_core_state_t             st_nxt;

   // flags gathered at their register bit positions
   logic [MIE_NREG-1:0][7:0]    flag_vec;
   // enable register contents, reserved bits already zero
   logic [MIE_NREG-1:0][7:0]    en_vec;
   // one address match per enable register
   logic [MIE_NREG-1:0]         hit_vec;
   // flags gated by their enables, before the register stage
   logic [MIE_NREG-1:0][7:0]    pend_vec;
   // any gated flag present
   logic                        any_pend;
   // read value of the addressed enable register
   logic [7:0]                  rd_val;

   // ------------------------------------------------------------------
   // enable registers, one per status register, each on its own address
   // ------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < MIE_NREG; gi++) begin : g_en
         mie_en_reg #(
            .ADDR (MIE_EN_OFS[gi]),
            .MASK (MIE_EN_MASK[gi])
         ) u_en (
            .clk       (MCLK),
            .rst_n     (RST_N),
            .sfr_addr  (SFR_ADDR),
            .sfr_wr    (SFR_WR),
            .sfr_wdata (SFR_WDATA),
            .hit       (hit_vec[gi]),
            .en        (en_vec[gi])
         );
      end
   endgenerate

   // the core's sfr mux takes our read data only when we decode
   assign SFR_HIT = |hit_vec;

   // ------------------------------------------------------------------
   // low status group; bits 7 and 6 carry no source
   // ------------------------------------------------------------------
   always_comb begin
      flag_vec[MIE_IDX_LOW]                             = 8'h00;
      flag_vec[MIE_IDX_LOW][MIE_B_FAULT_MODE_CHANGE]    = FAULT_MODE_CHANGE;
      flag_vec[MIE_IDX_LOW][MIE_B_REACTIVE_SIGN_CHANGE] = REACTIVE_SIGN_CHANGE;
      flag_vec[MIE_IDX_LOW][MIE_B_ACTIVE_SIGN_CHANGE]   = ACTIVE_SIGN_CHANGE;
      flag_vec[MIE_IDX_LOW][MIE_B_APPARENT_NO_LOAD]     = APPARENT_NO_LOAD;
      flag_vec[MIE_IDX_LOW][MIE_B_REACTIVE_NO_LOAD]     = REACTIVE_NO_LOAD;
      flag_vec[MIE_IDX_LOW][MIE_B_ACTIVE_NO_LOAD]       = ACTIVE_NO_LOAD;
      // mid status group; every bit carries a source
      // the pulse flags are sticky in the datapath, so each pulse counts
      flag_vec[MIE_IDX_MID]                             = 8'h00;
      flag_vec[MIE_IDX_MID][MIE_B_PULSE_OUTPUT_TWO]     = PULSE_OUTPUT_TWO;
      flag_vec[MIE_IDX_MID][MIE_B_PULSE_OUTPUT_ONE]     = PULSE_OUTPUT_ONE;
      flag_vec[MIE_IDX_MID][MIE_B_APPARENT_ENERGY_OVF]  = APPARENT_ENERGY_OVERFLOW;
      flag_vec[MIE_IDX_MID][MIE_B_REACTIVE_ENERGY_OVF]  = REACTIVE_ENERGY_OVERFLOW;
      flag_vec[MIE_IDX_MID][MIE_B_ACTIVE_ENERGY_OVF]    = ACTIVE_ENERGY_OVERFLOW;
      flag_vec[MIE_IDX_MID][MIE_B_APPARENT_ENERGY_HALF] = APPARENT_ENERGY_HALF_FULL;
      flag_vec[MIE_IDX_MID][MIE_B_REACTIVE_ENERGY_HALF] = REACTIVE_ENERGY_HALF_FULL;
      flag_vec[MIE_IDX_MID][MIE_B_ACTIVE_ENERGY_HALF]   = ACTIVE_ENERGY_HALF_FULL;
      // high status group; bit 7 is the datapath's reset marker, not a source
      // the waveform flag is taken as a level so the request lasts until
      // software clears the flag in the datapath
      flag_vec[MIE_IDX_HIGH]                              = 8'h00;
      flag_vec[MIE_IDX_HIGH][MIE_B_WAVEFORM_SAMPLE_READY] = WAVEFORM_SAMPLE_READY;
      flag_vec[MIE_IDX_HIGH][MIE_B_CURRENT_PEAK_EXCEEDED] = CURRENT_PEAK_EXCEEDED;
      flag_vec[MIE_IDX_HIGH][MIE_B_VOLTAGE_PEAK_EXCEEDED] = VOLTAGE_PEAK_EXCEEDED;
      flag_vec[MIE_IDX_HIGH][MIE_B_LINE_CYCLE_ACCUM_DONE] = LINE_CYCLE_ACCUM_DONE;
      flag_vec[MIE_IDX_HIGH][MIE_B_ZERO_CROSS_TIMEOUT]    = ZERO_CROSS_TIMEOUT;
      flag_vec[MIE_IDX_HIGH][MIE_B_ZERO_CROSS_DETECT]     = ZERO_CROSS_DETECT;
   end

   // ------------------------------------------------------------------
   // gate each flag by its enable; masked reserved enables gate nothing
   // ------------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < MIE_NREG; i++) begin
         pend_vec[i] = flag_vec[i] & en_vec[i] & MIE_EN_MASK[i];
      end
   end

   // a single enabled flag is enough to request service
   assign any_pend = |pend_vec;

   // ------------------------------------------------------------------
   // read mux over the three enable registers
   // ------------------------------------------------------------------
   always_comb begin
      rd_val = 8'h00;
      for (int i = 0; i < MIE_NREG; i++) begin
         if (hit_vec[i]) begin
            rd_val = en_vec[i];
         end
      end
   end

   // ------------------------------------------------------------------
   // next state: interrupt level, summary, per-source view, read data
   // both levels fall on the MCLK edge after the last enabled flag is cleared or
   // its cleared enable takes effect; there is no separate latch to clear
   // ------------------------------------------------------------------
   always_comb begin
      st_nxt         = st_r;
      st_nxt.irq     = any_pend;
      st_nxt.summary = any_pend;
      st_nxt.pend    = pend_vec;
      if (SFR_RD && SFR_HIT) begin
         st_nxt.rdata = rd_val;
      end
   end

   // ------------------------------------------------------------------
   // state register; nothing pending and read data zero after reset
   // ------------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         st_r.irq     <= 1'b0;
         st_r.summary <= 1'b0;
         st_r.rdata   <= MIE_RDATA_RST;
         st_r.pend    <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------------
   // outputs other than SFR_HIT, all from the state register
   // ------------------------------------------------------------------
   assign MEAS_IRQ          = st_r.irq;
   assign MEAS_IRQ_SUMMARY  = st_r.summary;
   assign MEAS_IRQ_SRC_LOW  = st_r.pend[MIE_IDX_LOW];
   assign MEAS_IRQ_SRC_MID  = st_r.pend[MIE_IDX_MID];
   assign MEAS_IRQ_SRC_HIGH = st_r.pend[MIE_IDX_HIGH];
   assign SFR_RDATA         = st_r.rdata;

endmodule // mie_irq_core

// ---- bench/mie_irq_core_asserts.sv ----
// port assertions for the measurement interrupt enable block
`timescale 1ns/100ps
module mie_irq_core_asserts
   import mie_pkg::*;
(
   input wire logic       MCLK,
   input wire logic       RST_N,
   input wire logic [7:0] SFR_ADDR,
   input wire logic       SFR_WR,
   input wire logic       SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   input wire logic [7:0] SFR_RDATA,
   input wire logic       FAULT_MODE_CHANGE,
   input wire logic       PULSE_OUTPUT_TWO,
   input wire logic       WAVEFORM_SAMPLE_READY,
   input wire logic       ZERO_CROSS_DETECT,
   input wire logic       MEAS_IRQ,
   input wire logic       MEAS_IRQ_SUMMARY,
   input wire logic [7:0] MEAS_IRQ_SRC_LOW,
   input wire logic [7:0] MEAS_IRQ_SRC_MID,
   input wire logic [7:0] MEAS_IRQ_SRC_HIGH
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   // enabling write of zero-cross source, then its flag held with no write
   sequence zx_enable_s;
      SFR_WR && SFR_ADDR == MIE_EN_HIGH_OFS && SFR_WDATA[0];
   endsequence
   sequence zx_set_s;
      ZERO_CROSS_DETECT && !SFR_WR;
   endsequence
   irq_or_src_a: assert property (MEAS_IRQ == |{MEAS_IRQ_SRC_LOW, MEAS_IRQ_SRC_MID, MEAS_IRQ_SRC_HIGH})
      else $error("irq differs from source or");
   summary_match_a: assert property (MEAS_IRQ_SUMMARY == MEAS_IRQ)
      else $error("summary differs from irq");
   reserved_inert_a: assert property (MEAS_IRQ_SRC_LOW[7:6] == 2'h0 && MEAS_IRQ_SRC_HIGH[7:6] == 2'h0)
      else $error("reserved bit raised a source");
   reset_quiet_a: assert property ($rose(RST_N) |-> !MEAS_IRQ)
      else $error("irq pending right after reset");
   zx_raise_a: assert property (zx_enable_s ##1 zx_set_s |=> MEAS_IRQ && MEAS_IRQ_SRC_HIGH[0])
      else $error("enabled zero-cross flag gave no irq");
   zx_clear_a: assert property (MEAS_IRQ_SRC_HIGH[0] && !ZERO_CROSS_DETECT |=> !MEAS_IRQ_SRC_HIGH[0])
      else $error("zero-cross source stuck");
   wave_hold_a: assert property (MEAS_IRQ_SRC_HIGH[5] && WAVEFORM_SAMPLE_READY && !SFR_WR |=> MEAS_IRQ)
      else $error("waveform irq dropped early");
   fault_cause_a: assert property (MEAS_IRQ_SRC_LOW[5] |-> $past(FAULT_MODE_CHANGE))
      else $error("fault source without flag");
   pulse_cause_a: assert property (MEAS_IRQ_SRC_MID[7] |-> $past(PULSE_OUTPUT_TWO))
      else $error("pulse two source without flag");
   readback_low_a: assert property (SFR_RD && SFR_ADDR == MIE_EN_LOW_OFS |=> SFR_RDATA[7:6] == 2'h0)
      else $error("low enable reserved bits read back");
endmodule // mie_irq_core_asserts

bind mie_irq_core mie_irq_core_asserts u_chk (.MCLK, .RST_N, .SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_WDATA,
   .SFR_RDATA, .FAULT_MODE_CHANGE, .PULSE_OUTPUT_TWO, .WAVEFORM_SAMPLE_READY, .ZERO_CROSS_DETECT,
   .MEAS_IRQ, .MEAS_IRQ_SUMMARY, .MEAS_IRQ_SRC_LOW, .MEAS_IRQ_SRC_MID, .MEAS_IRQ_SRC_HIGH);

// ---- bench/mie_core_model.sv ----
// core-side model counting measurement interrupt requests
`timescale 1ns/100ps
module mie_core_model (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       irq,
   output logic      [7:0] irq_cnt
);
   logic irq_d;
   // one request taken per rising level of the pending line
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_d   <= 1'b0;
         irq_cnt <= 8'h00;
      end else begin
         irq_d <= irq;
         if (irq && !irq_d) begin
            irq_cnt <= irq_cnt + 8'h01;
         end
      end
   end
endmodule // mie_core_model

// ---- bench/test_measurement_irq_enable.sv ----
// self-checking bench for the measurement interrupt enable block
`timescale 1ns/100ps
module test_measurement_irq_enable
   import mie_pkg::*;
;
   logic        mclk, rst_n, wr, rd, hit, irq, summ;
   logic [7:0]  addr, wdata, rdata, src_l, src_m, src_h, irq_cnt, exp_cnt;
   logic [5:0]  fl, fh;
   logic [7:0]  fm;
   logic [23:0] one;
   int          error_cnt, compares;

   mie_irq_core dut_u (.MCLK(mclk), .RST_N(rst_n), .SFR_ADDR(addr), .SFR_WR(wr), .SFR_RD(rd),
      .SFR_WDATA(wdata), .SFR_RDATA(rdata), .SFR_HIT(hit),
      .FAULT_MODE_CHANGE(fl[5]), .REACTIVE_SIGN_CHANGE(fl[4]), .ACTIVE_SIGN_CHANGE(fl[3]),
      .APPARENT_NO_LOAD(fl[2]), .REACTIVE_NO_LOAD(fl[1]), .ACTIVE_NO_LOAD(fl[0]),
      .PULSE_OUTPUT_TWO(fm[7]), .PULSE_OUTPUT_ONE(fm[6]), .APPARENT_ENERGY_OVERFLOW(fm[5]),
      .REACTIVE_ENERGY_OVERFLOW(fm[4]), .ACTIVE_ENERGY_OVERFLOW(fm[3]), .APPARENT_ENERGY_HALF_FULL(fm[2]),
      .REACTIVE_ENERGY_HALF_FULL(fm[1]), .ACTIVE_ENERGY_HALF_FULL(fm[0]),
      .WAVEFORM_SAMPLE_READY(fh[5]), .CURRENT_PEAK_EXCEEDED(fh[4]), .VOLTAGE_PEAK_EXCEEDED(fh[3]),
      .LINE_CYCLE_ACCUM_DONE(fh[2]), .ZERO_CROSS_TIMEOUT(fh[1]), .ZERO_CROSS_DETECT(fh[0]),
      .MEAS_IRQ(irq), .MEAS_IRQ_SUMMARY(summ), .MEAS_IRQ_SRC_LOW(src_l), .MEAS_IRQ_SRC_MID(src_m),
      .MEAS_IRQ_SRC_HIGH(src_h));
   mie_core_model core_u (.mclk(mclk), .rst_n(rst_n), .irq(irq), .irq_cnt(irq_cnt));

   // clock source
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // compare tasks, verdict and bus cycles
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_pend(input logic e, input logic [23:0] es);
      compares++;
      if ({irq, summ, src_h, src_m, src_l} !== {e, e, es}) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, {irq, summ, src_h, src_m, src_l}, {e, e, es});
      end
   endtask
   task automatic finish_test();
      $display("errors=%0d compares=%0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic settle();
      @(negedge mclk);
      @(negedge mclk);
   endtask
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      chk(rdata, e);
   endtask
   // status-bit layout to the twenty flag lines
   task automatic set_flags(input logic [23:0] x);
      @(posedge mclk);
      {fh, fm, fl} <= {x[21:16], x[15:8], x[5:0]};
      settle();
   endtask

   // watchdog against a hang
   initial begin
      #2000000;
      error_cnt++;
      finish_test();
   end

   // main sequence
   initial begin
      {rst_n, wr, rd, addr, wdata, fl, fm, fh, exp_cnt} = '0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      set_flags(24'hffffff);
      chk_pend(1'b0, 24'h0);
      for (int r = 0; r < MIE_NREG; r++) begin
         sfr_rd(MIE_EN_OFS[r], MIE_EN_RST);
      end
      // each source refused while disabled, raised once enabled
      for (int r = 0; r < MIE_NREG; r++) begin
         for (int b = 0; b < 8; b++) begin
            if (MIE_EN_MASK[r][b]) begin
               one = 24'h1 << (8 * r + b);
               set_flags(one);
               chk_pend(1'b0, 24'h0);
               sfr_wr(MIE_EN_OFS[r], 8'h01 << b);
               settle();
               chk_pend(1'b1, one);
               exp_cnt++;
               set_flags(~one);
               chk_pend(1'b0, 24'h0);
               sfr_wr(MIE_EN_OFS[r], 8'h00);
            end
         end
      end
      // summary holds until the last enabled flag clears
      sfr_wr(MIE_EN_LOW_OFS, 8'h09);
      set_flags(24'h000009);
      chk_pend(1'b1, 24'h000009);
      set_flags(24'h000008);
      chk_pend(1'b1, 24'h000008);
      set_flags(24'h0);
      chk_pend(1'b0, 24'h0);
      exp_cnt++;
      // waveform interrupt stands until its flag is cleared
      sfr_wr(MIE_EN_HIGH_OFS, 8'h20);
      set_flags(24'h200000);
      repeat (10) @(negedge mclk);
      chk_pend(1'b1, 24'h200000);
      set_flags(24'h0);
      chk_pend(1'b0, 24'h0);
      exp_cnt++;
      chk(irq_cnt, exp_cnt);
      // writable bits, unmapped place, then a second reset
      for (int r = 0; r < MIE_NREG; r++) begin
         sfr_wr(MIE_EN_OFS[r], 8'hff);
         sfr_rd(MIE_EN_OFS[r], MIE_EN_MASK[r]);
      end
      sfr_wr(8'h50, 8'h00);
      sfr_rd(8'h50, MIE_EN_HIGH_MASK);
      chk({7'h00, hit}, 8'h00);
      sfr_rd(MIE_EN_LOW_OFS, MIE_EN_LOW_MASK);
      chk({7'h00, hit}, 8'h01);
      set_flags(24'hffffff);
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      settle();
      chk_pend(1'b0, 24'h0);
      sfr_rd(MIE_EN_MID_OFS, MIE_EN_RST);
      finish_test();
   end
endmodule // test_measurement_irq_enable
